// File: adrpc_ctrl.sv
// Reset and power-down sequencer for the audio signal processor
`timescale 1ns/1ps
`default_nettype none

`include "adrpc_regs.svh"

// Overview of operation
// RL1 - Reset input acts asynchronously, restoring every internal part to defaults.
// RL2 - Reset is active low; device stays in reset while input is 0.
// RL3 - During reset the arithmetic core idles and controller initialisation starts.
// RL4 - System must supply a valid master clock when reset is released.
// RL5 - Internal supply regulators also reset the device at power turn-on.
// RL6 - Power-down input low stops all logic and every internal clock; the code freezes the walk and gates clocks_run, bus_accept and the write strobes.
// RL7 - Coefficient memory stays unchanged through the whole power-down cycle.
// RL8 - While reset is low, control and serial audio buses are ignored.
// RL9 - Reset release starts housekeeping: memory clear, then default values load.
// RL10 - After housekeeping the master port is enabled, slave port stays disabled.
// RL11 - Power-down keeps full internal state so operation resumes on release.
// RL12 - Reset release is synchronised to the master clock.
module adrpc_ctrl #(
    parameter int CLEAR_WORDS     = `ADRPC_CLEAR_WORDS,
    parameter int ADDR_W          = `ADRPC_CLEAR_AW,
    parameter int DEFAULTS_CYCLES = `ADRPC_DEFAULTS_CYCLES
) (
    // Master clock and power-on reset from the regulators
    input  wire logic              clk,
    input  wire logic              reset,
    // Pins from the system controller
    input  wire logic              device_reset_n,
    input  wire logic              power_down_n,
    // Core and embedded controller control
    output logic                   core_idle,
    output logic                   ctrl_init,
    output logic                   init_done,
    // Housekeeping
    output logic                   mem_clr_we,
    output logic [ADDR_W-1:0]      mem_clr_addr,
    output logic                   defaults_load,
    // Port enables
    output logic                   master_port_en,
    output logic                   slave_port_en,
    output logic                   bus_accept,
    // Clock and memory protection
    output logic                   clocks_run,
    output logic                   coef_wr_allow
);

    localparam int DEF_W = $clog2(DEFAULTS_CYCLES + 1);
    localparam logic [ADDR_W-1:0] CLR_LAST = ADDR_W'(CLEAR_WORDS - 1);
    localparam logic [DEF_W-1:0]  DEF_LAST = DEF_W'(DEFAULTS_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (CLEAR_WORDS < 2 || CLEAR_WORDS > (1 << ADDR_W) || DEFAULTS_CYCLES < 1) begin : g_bad
        $error("adrpc_ctrl: CLEAR_WORDS or DEFAULTS_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers
    adrpc_sync_if u_sb ();

    adrpc_sync u_sync (
        .clk            (clk),
        .reset          (reset),
        .device_reset_n (device_reset_n),
        .power_down_n   (power_down_n),
        .sb             (u_sb.src)
    );

    logic rst_int;
    logic pdn_s;
    logic freeze;

    assign rst_int = u_sb.rst_int;
    assign pdn_s   = u_sb.pdn_sync;
    // Power-down freezes the walk registers: the clocks are deemed stopped
    assign freeze  = ~pdn_s; // RL6 RL11

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    adrpc_pkg::adrpc_state_type state_r;
    adrpc_pkg::adrpc_state_type state_nxt;
    logic [ADDR_W-1:0]          clr_addr_r;
    logic [ADDR_W-1:0]          clr_addr_nxt;
    logic [DEF_W-1:0]           def_cnt_r;
    logic [DEF_W-1:0]           def_cnt_nxt;

    // Housekeeping walk; nothing advances while powered down
    always_comb begin
        state_nxt    = state_r;
        clr_addr_nxt = clr_addr_r;
        def_cnt_nxt  = def_cnt_r;
        if (!freeze) begin // RL11
            case (state_r)
                adrpc_pkg::ST_RESET: begin
                    state_nxt    = adrpc_pkg::ST_CLEAR; // RL9
                    clr_addr_nxt = '0;
                end
                adrpc_pkg::ST_CLEAR: begin
                    if (clr_addr_r == CLR_LAST) begin
                        state_nxt   = adrpc_pkg::ST_DEFAULTS; // RL9
                        def_cnt_nxt = '0;
                    end else begin
                        clr_addr_nxt = clr_addr_r + ADDR_W'(1);
                    end
                end
                adrpc_pkg::ST_DEFAULTS: begin
                    if (def_cnt_r == DEF_LAST) begin
                        state_nxt = adrpc_pkg::ST_RUN; // RL10
                    end else begin
                        def_cnt_nxt = def_cnt_r + DEF_W'(1);
                    end
                end
                adrpc_pkg::ST_RUN: begin
                    state_nxt = adrpc_pkg::ST_RUN;
                end
                default: begin
                    state_nxt = adrpc_pkg::ST_RESET;
                end
            endcase
        end
    end

    // Async reset returns the walk to its start
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            state_r    <= adrpc_pkg::ST_RESET; // RL1
            clr_addr_r <= ADDR_W'(`ADRPC_CLEAR_ADDR_RST); // Header value is 10 bits wide
            def_cnt_r  <= '0;
        end else begin
            state_r    <= state_nxt;
            clr_addr_r <= clr_addr_nxt;
            def_cnt_r  <= def_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic core_idle_r,      core_idle_nxt;
    logic ctrl_init_r,      ctrl_init_nxt;
    logic init_done_r,      init_done_nxt;
    logic mem_clr_we_r,     mem_clr_we_nxt;
    logic defaults_load_r,  defaults_load_nxt;
    logic master_port_en_r, master_port_en_nxt;
    logic slave_port_en_r,  slave_port_en_nxt;
    logic bus_accept_r,     bus_accept_nxt;
    logic clocks_run_r,     clocks_run_nxt;
    logic coef_wr_allow_r,  coef_wr_allow_nxt;
    logic running;

    // Outputs follow the next state so they line up with the walk
    always_comb begin
        running            = (state_nxt == adrpc_pkg::ST_RUN);
        core_idle_nxt      = !running || freeze; // RL3
        ctrl_init_nxt      = !running; // RL3
        init_done_nxt      = running;
        mem_clr_we_nxt     = (state_nxt == adrpc_pkg::ST_CLEAR) && !freeze; // RL7 RL9
        defaults_load_nxt  = (state_nxt == adrpc_pkg::ST_DEFAULTS) && !freeze; // RL9
        master_port_en_nxt = running; // RL10
        slave_port_en_nxt  = 1'b0; // RL10
        bus_accept_nxt     = running && !freeze; // RL8
        clocks_run_nxt     = !freeze; // RL6
        coef_wr_allow_nxt  = running && !freeze; // RL7
    end

    // Reset values hold the core idle and the controller in init
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            core_idle_r      <= 1'b1; // RL3
            ctrl_init_r      <= 1'b1; // RL3
            init_done_r      <= 1'b0;
            mem_clr_we_r     <= 1'b0;
            defaults_load_r  <= 1'b0;
            master_port_en_r <= 1'b0;
            slave_port_en_r  <= 1'b0;
            bus_accept_r     <= 1'b0; // RL8
            clocks_run_r     <= 1'b1;
            coef_wr_allow_r  <= 1'b0;
        end else begin
            core_idle_r      <= core_idle_nxt;
            ctrl_init_r      <= ctrl_init_nxt;
            init_done_r      <= init_done_nxt;
            mem_clr_we_r     <= mem_clr_we_nxt;
            defaults_load_r  <= defaults_load_nxt;
            master_port_en_r <= master_port_en_nxt;
            slave_port_en_r  <= slave_port_en_nxt;
            bus_accept_r     <= bus_accept_nxt;
            clocks_run_r     <= clocks_run_nxt;
            coef_wr_allow_r  <= coef_wr_allow_nxt;
        end
    end

    assign core_idle      = core_idle_r;
    assign ctrl_init      = ctrl_init_r;
    assign init_done      = init_done_r;
    assign mem_clr_we     = mem_clr_we_r;
    assign mem_clr_addr   = clr_addr_r;
    assign defaults_load  = defaults_load_r;
    assign master_port_en = master_port_en_r;
    assign slave_port_en  = slave_port_en_r;
    assign bus_accept     = bus_accept_r;
    assign clocks_run     = clocks_run_r;
    assign coef_wr_allow  = coef_wr_allow_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_idle_until_done;
        @(posedge clk) disable iff (rst_int)
        !init_done_r |-> core_idle_r && ctrl_init_r;
    endproperty
    a_idle_until_done: assert property (p_idle_until_done) // RL3
        else $error("core not idle before initialisation finished");

    // The edge that drops the internal reset still finds the walk held, so wait one more
    property p_release_starts_clear;
        @(posedge clk) disable iff (rst_int)
        !rst_int && state_r == adrpc_pkg::ST_RESET && pdn_s
            |=> state_r == adrpc_pkg::ST_CLEAR && mem_clr_we_r && clr_addr_r == '0;
    endproperty
    a_release_starts_clear: assert property (p_release_starts_clear) // RL9
        else $error("memory clear did not start after reset release");

    property p_clear_then_defaults;
        @(posedge clk) disable iff (rst_int)
        mem_clr_we_r && clr_addr_r == CLR_LAST && pdn_s |=> !mem_clr_we_r && defaults_load_r;
    endproperty
    a_clear_then_defaults: assert property (p_clear_then_defaults) // RL9
        else $error("default load did not follow the last cleared word");

    // The load strobe drops while frozen, so the phase itself is what must precede
    property p_ports_after_init;
        @(posedge clk) disable iff (rst_int)
        $rose(init_done_r) |-> master_port_en_r && !slave_port_en_r
            && $past(state_r == adrpc_pkg::ST_DEFAULTS);
    endproperty
    a_ports_after_init: assert property (p_ports_after_init) // RL10
        else $error("port enables wrong when initialisation completed");

    property p_buses_ignored;
        @(posedge clk) disable iff (rst_int)
        !init_done_r |-> !bus_accept_r && !master_port_en_r;
    endproperty
    a_buses_ignored: assert property (p_buses_ignored) // RL8
        else $error("bus accepted before initialisation finished");

    property p_clocks_stop;
        @(posedge clk) disable iff (rst_int)
        !pdn_s |=> !clocks_run_r && !bus_accept_r && core_idle_r;
    endproperty
    a_clocks_stop: assert property (p_clocks_stop) // RL6
        else $error("clocks still running during power-down");

    property p_coef_protected;
        @(posedge clk) disable iff (rst_int)
        !clocks_run_r |-> !coef_wr_allow_r && !mem_clr_we_r;
    endproperty
    a_coef_protected: assert property (p_coef_protected) // RL7
        else $error("memory write allowed during power-down");

    property p_state_kept;
        @(posedge clk) disable iff (rst_int)
        !pdn_s |=> $stable(state_r) && $stable(clr_addr_r) && $stable(def_cnt_r);
    endproperty
    a_state_kept: assert property (p_state_kept) // RL11
        else $error("internal state changed during power-down");

endmodule

`default_nettype wire

// File: adrpc_pkg.sv
// Types shared by the reset and power-down controller
package adrpc_pkg;

    // Initialisation sequence after reset release
    typedef enum {
        ST_RESET,
        ST_CLEAR,
        ST_DEFAULTS,
        ST_RUN
    } adrpc_state_type;

endpackage

// File: adrpc_regs.svh
// Timing counts and sizes for the reset and power-down controller
`ifndef ADRPC_REGS_SVH
`define ADRPC_REGS_SVH

// Flip-flops in each synchroniser chain
`define ADRPC_SYNC_STAGES     2
// Words wiped by the memory clear after reset release
`define ADRPC_CLEAR_WORDS     1024
// Address width of the memory clear walk
`define ADRPC_CLEAR_AW        10
// Cycles spent loading default register values
`define ADRPC_DEFAULTS_CYCLES 16
// Reset value of the clear address
`define ADRPC_CLEAR_ADDR_RST  10'h000

`endif

// File: adrpc_sync.sv
// Reset merge and synchronisers for the reset and power-down pins
`timescale 1ns/1ps
`default_nettype none

`include "adrpc_regs.svh"

module adrpc_sync (
    // Clock and power-on reset
    input  wire logic clk,
    input  wire logic reset,
    // Pins from the system controller
    input  wire logic device_reset_n,
    input  wire logic power_down_n,
    // Synchronised levels
    adrpc_sync_if.src sb
);

    localparam int STAGES = `ADRPC_SYNC_STAGES;

    logic              rst_any;
    logic [STAGES-1:0] rst_sync_r;
    logic [STAGES-1:0] rst_sync_nxt;
    logic [STAGES-1:0] pdn_sync_r;
    logic [STAGES-1:0] pdn_sync_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Either source of reset acts at once, no clock needed
    assign rst_any = reset | ~device_reset_n; // RL1 RL2 RL5

    // Shift chains; stage 0 feeds stage 1 only
    always_comb begin
        rst_sync_nxt = {rst_sync_r[STAGES-2:0], 1'b0};
        pdn_sync_nxt = {pdn_sync_r[STAGES-2:0], power_down_n};
    end

    // Release ripples out on clock edges so sequencing starts cleanly
    always_ff @(posedge clk or posedge rst_any) begin
        if (rst_any) begin
            rst_sync_r <= '1; // RL12
            pdn_sync_r <= '1;
        end else begin
            rst_sync_r <= rst_sync_nxt;
            pdn_sync_r <= pdn_sync_nxt;
        end
    end

    assign sb.rst_int  = rst_sync_r[STAGES-1];
    assign sb.pdn_sync = pdn_sync_r[STAGES-1];

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_reset_pin_async;
        @(posedge clk) disable iff (reset)
        !device_reset_n |-> sb.rst_int;
    endproperty
    a_reset_pin_async: assert property (p_reset_pin_async) // RL1
        else $error("reset pin low but internal reset not asserted");

    property p_release_synced;
        @(posedge clk) disable iff (reset)
        $fell(sb.rst_int) |-> $past(device_reset_n) && $past(device_reset_n, 2);
    endproperty
    a_release_synced: assert property (p_release_synced) // RL12
        else $error("internal reset released without two clean edges");

endmodule

`default_nettype wire

// File: adrpc_sync_if.sv
// Carrier for the synchronised reset and power-down levels
`timescale 1ns/1ps
`default_nettype none

interface adrpc_sync_if;
    logic rst_int;  // Internal reset, async assert, clocked release
    logic pdn_sync; // Power-down pin, active low, after two flops

    modport src (output rst_int, output pdn_sync);
    modport sink (input rst_int, input pdn_sync);
endinterface

`default_nettype wire

// File: adrpc_sysctl_model.sv
// System controller model that drives the reset and power-down pins
`timescale 1ns/1ps
`default_nettype none

module adrpc_sysctl_model (
    // Master clock as seen by the controller
    input  wire logic clk,
    // Pins towards the device
    output var  logic device_reset_n,
    output var  logic power_down_n
);
    // Both pins idle high, the level their pull-ups would give
    initial begin
        device_reset_n = 1'h1;
        power_down_n   = 1'h1;
    end

    // Reset pin driven to 0 starts a reset
    task automatic reset_assert();
        @(negedge clk);
        device_reset_n = 1'h0;
    endtask

    // Reset released only on a running clock edge
    task automatic reset_release();
        @(negedge clk);
        device_reset_n = 1'h1;
    endtask

    // Power-down pin, active low, changed away from the sampling edge
    task automatic pdn_enter();
        @(negedge clk);
        power_down_n = 1'h0;
    endtask

    // Power-down released, again away from the sampling edge
    task automatic pdn_leave();
        @(negedge clk);
        power_down_n = 1'h1;
    endtask
endmodule

`default_nettype wire

// File: test_audio_dsp_reset_powerdown_ctrl.sv
// Self-checking bench for the reset and power-down controller
`timescale 1ns/1ps
`default_nettype none

module test_audio_dsp_reset_powerdown_ctrl;
    // Short housekeeping counts keep each walk to a few cycles
    localparam int CW = 4;
    localparam int AW = 2;
    localparam int DC = 2;

    logic          clk;
    logic          reset;
    wire logic     device_reset_n;
    wire logic     power_down_n;
    wire logic     core_idle;
    wire logic     ctrl_init;
    wire logic     init_done;
    wire logic     mem_clr_we;
    wire logic [AW-1:0] mem_clr_addr;
    wire logic     defaults_load;
    wire logic     master_port_en;
    wire logic     slave_port_en;
    wire logic     bus_accept;
    wire logic     clocks_run;
    wire logic     coef_wr_allow;
    int            fails;
    int            total_checks;
    int            clr_cnt;
    logic [CW-1:0] clr_mask;
    logic [AW-1:0] held;

    adrpc_sysctl_model i_adrpc_sysctl_model (
        .clk            (clk),
        .device_reset_n (device_reset_n),
        .power_down_n   (power_down_n)
    );

    adrpc_ctrl #(.CLEAR_WORDS(CW), .ADDR_W(AW), .DEFAULTS_CYCLES(DC)) i_adrpc_ctrl (
        .clk            (clk),
        .reset          (reset),
        .device_reset_n (device_reset_n),
        .power_down_n   (power_down_n),
        .core_idle      (core_idle),
        .ctrl_init      (ctrl_init),
        .init_done      (init_done),
        .mem_clr_we     (mem_clr_we),
        .mem_clr_addr   (mem_clr_addr),
        .defaults_load  (defaults_load),
        .master_port_en (master_port_en),
        .slave_port_en  (slave_port_en),
        .bus_accept     (bus_accept),
        .clocks_run     (clocks_run),
        .coef_wr_allow  (coef_wr_allow)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial clk = 1'h0;
    always #25 clk = ~clk;

    // Tally clear strobes so a stalled or doubled word shows up
    always @(negedge clk) begin
        if (mem_clr_we === 1'h1) begin
            clr_cnt <= clr_cnt + 1;
            clr_mask[mem_clr_addr] <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Outputs that follow the sequencer phase while clocks run
    task automatic chk_state(input logic idle, input logic we, input logic dl, input logic done);
        chk("core_idle", core_idle, idle);
        chk("ctrl_init", ctrl_init, idle);
        chk("mem_clr_we", mem_clr_we, we);
        chk("defaults_load", defaults_load, dl);
        chk("init_done", init_done, done);
        chk("master_port_en", master_port_en, done);
        chk("slave_port_en", slave_port_en, 1'h0);
        chk("bus_accept", bus_accept, done);
        chk("coef_wr_allow", coef_wr_allow, done);
        chk("clocks_run", clocks_run, 1'h1);
    endtask

    // Walk from a release made at this falling edge, edge by edge
    task automatic run_walk();
        int i;
        clr_cnt  = 0;
        clr_mask = '0;
        for (i = 1; i <= 3 + CW + DC; i++) begin
            @(negedge clk);
            chk_state(i < 3 + CW + DC, i >= 3 && i < 3 + CW, i >= 3 + CW && i < 3 + CW + DC, i >= 3 + CW + DC);
            if (i >= 3 && i < 3 + CW) chk("mem_clr_addr", mem_clr_addr, i - 3);
        end
        chk("clear_count", clr_cnt, CW);
        chk("clear_mask", clr_mask, {CW{1'h1}});
    endtask

    // Reset seen at once, with no clock edge in between
    task automatic pin_reset_now();
        i_adrpc_sysctl_model.reset_assert();
        #5;
        chk_state(1'h1, 1'h0, 1'h0, 1'h0);
        chk("mem_clr_addr", mem_clr_addr, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_power_on();
        repeat (5) @(negedge clk);
        chk_state(1'h1, 1'h0, 1'h0, 1'h0);
        reset = 1'h0;
        run_walk();
    endtask

    task automatic sc_pin_reset();
        pin_reset_now();
        i_adrpc_sysctl_model.reset_release();
        repeat (4) @(negedge clk);
        pin_reset_now();
        i_adrpc_sysctl_model.reset_release();
        run_walk();
    endtask

    task automatic sc_regulator_reset();
        @(negedge clk);
        reset = 1'h1;
        #5;
        chk_state(1'h1, 1'h0, 1'h0, 1'h0);
        @(negedge clk);
        reset = 1'h0;
        run_walk();
    endtask

    // Power-down in mid-clear: everything freezes, then the walk resumes
    task automatic sc_pd_walk();
        int n;
        pin_reset_now();
        i_adrpc_sysctl_model.reset_release();
        clr_cnt  = 0;
        clr_mask = '0;
        repeat (2) @(negedge clk);
        i_adrpc_sysctl_model.pdn_enter();
        repeat (2) @(negedge clk);
        chk("clocks_run", clocks_run, 1'h1);
        @(negedge clk);
        chk("clocks_run", clocks_run, 1'h0);
        chk("core_idle", core_idle, 1'h1);
        held = mem_clr_addr;
        for (n = 0; n < 4; n++) begin
            @(negedge clk);
            chk("mem_clr_we", mem_clr_we, 1'h0);
            chk("mem_clr_addr", mem_clr_addr, held);
        end
        i_adrpc_sysctl_model.pdn_leave();
        repeat (2) @(negedge clk);
        chk("clocks_run", clocks_run, 1'h0);
        @(negedge clk);
        chk("clocks_run", clocks_run, 1'h1);
        n = 0;
        while (init_done !== 1'h1 && n < 3 + CW + DC) begin
            @(negedge clk);
            n++;
        end
        chk("init_done", init_done, 1'h1);
        chk("clear_count", clr_cnt, CW);
        chk("clear_mask", clr_mask, {CW{1'h1}});
    endtask

    // Power-down after init: clocks stop, port state is kept
    task automatic sc_pd_run();
        i_adrpc_sysctl_model.pdn_enter();
        repeat (3) @(negedge clk);
        chk("clocks_run", clocks_run, 1'h0);
        chk("bus_accept", bus_accept, 1'h0);
        chk("coef_wr_allow", coef_wr_allow, 1'h0);
        chk("master_port_en", master_port_en, 1'h1);
        chk("init_done", init_done, 1'h1);
        i_adrpc_sysctl_model.pdn_leave();
        repeat (3) @(negedge clk);
        chk_state(1'h0, 1'h0, 1'h0, 1'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Cut a hang short
    initial begin
        #(5000 * 50);
        fails++;
        end_sim();
    end

    initial begin
        fails        = 0;
        total_checks = 0;
        clr_cnt      = 0;
        clr_mask     = '0;
        reset        = 1'h1;
        sc_power_on();
        sc_pin_reset();
        sc_pd_run();
        sc_regulator_reset();
        sc_pd_walk();
        end_sim();
    end
endmodule

`default_nettype wire
